// ==== hw/irc_carrier_gen.v ====
// Purpose: infrared carrier generator with envelope gating, Avalon-MM slave
// Assumes: count_tick_i is a one-cycle pulse per count clock, same domain
// Notes:   see the notes on behaviour below
//
// Notes on behaviour
// - enable starts count at zero, carrier default
// - low match: pulse, clear, invert, go high
// - high match: pulse, clear, invert, go low
// - period N+M+2, high time M+1
// - envelope event resynchronised to count clock
// - event copies next envelope into active
// - with remote enable, active high passes carrier, else low
// - output starts at carrier rising edge
// - falling envelope keeps full high pulse
// - high compare write latched, three-clock guard
// - after transfer next high compare uses it
// - clearing run stops and halts counting
// - control holds remote enable and next envelope
// - output table of remote enable and envelope
// - transfer on second count clock after event
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "irc_defs.vh"

module irc_carrier_gen (
    input  wire        clk_sys_i,               // system clock, 250 MHz
    input  wire        srst_i,                  // synchronous reset, active high
    input  wire        count_tick_i,            // count clock pulse
    input  wire        envelope_timer_irq_i,    // envelope event from companion timer
    input  wire [4:0]  avs_address_i,           // byte address
    input  wire        avs_read_i,              // read request
    input  wire        avs_write_i,             // write request
    input  wire [31:0] avs_writedata_i,         // write data
    input  wire [3:0]  avs_byteenable_i,        // byte enables
    output wire [31:0] avs_readdata_o,          // read data
    output wire        avs_waitrequest_o,       // stall, low for one answer cycle
    output wire        carrier_output_pin_o,    // gated carrier pin
    output wire        compare_match_irq_o,     // one-cycle pulse per match
    output wire        synced_envelope_event_o, // one-cycle synced envelope pulse
    output wire        envelope_timer_run_o     // run level to companion timer
);

    // ------------------------------------------------------------------
    // decode helper
    // ------------------------------------------------------------------
    function hit;
        input [`IRC_ADDR_W-1:0] addr;
        input [`IRC_ADDR_W-1:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg        run_reg;
    reg        env_run_reg;
    reg        remote_en_reg;
    reg        next_env_reg;
    reg        active_env_reg;
    reg [7:0]  low_cmp_reg;
    reg [7:0]  high_cmp_reg;
    reg [7:0]  high_latch_reg;
    reg        high_pend_reg;
    reg [1:0]  high_age_reg;
    reg [7:0]  cnt_reg;
    reg        phase_reg;
    reg        carrier_reg;
    reg        mask_reg;
    reg        gate_reg;
    reg        out_reg;
    reg        cmi_reg;
    reg        sev_reg;
    reg        env_sync_d_reg;
    reg        env_seen_reg;
    reg [1:0]  xfer_sr_reg;
    reg        wait_reg;
    reg [31:0] rdata_reg;

    wire       env_sync;
    wire       lane0;
    wire       wr_acc;
    wire       rd_start;
    wire       env_rise;
    wire       env_event;
    wire [7:0] cmp_sel;
    wire       match;
    wire       counting;

    reg        carrier_next;
    reg        gate_next;
    reg [31:0] rdata_next;

    // ------------------------------------------------------------------
    // envelope event synchroniser
    // ------------------------------------------------------------------
    irc_sync u_env_sync (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .async_i   (envelope_timer_irq_i),
        .sync_o    (env_sync)
    );

    // short pulses between ticks are held until the next count clock
    assign env_rise  = env_sync & ~env_sync_d_reg;
    assign env_event = count_tick_i & (env_seen_reg | env_rise);

    // ------------------------------------------------------------------
    // bus handshake: one stall cycle, answer on the second edge
    // ------------------------------------------------------------------
    assign lane0    = avs_byteenable_i[0];
    assign wr_acc   = avs_write_i & ~wait_reg & lane0;
    assign rd_start = avs_read_i & wait_reg;

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            wait_reg  <= 1'b1;
            rdata_reg <= `IRC_DATA_ZERO;
        end else begin
            if ((avs_read_i | avs_write_i) & wait_reg) begin
                wait_reg <= 1'b0;
            end else begin
                wait_reg <= 1'b1;
            end
            if (rd_start) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    always @* begin
        rdata_next = `IRC_DATA_ZERO;
        if (hit(avs_address_i, `IRC_OFS_RUN_CTRL)) begin
            rdata_next[`IRC_BIT_RUN]     = run_reg;
            rdata_next[`IRC_BIT_ENV_RUN] = env_run_reg;
        end else if (hit(avs_address_i, `IRC_OFS_LOW_CMP)) begin
            rdata_next[`IRC_CMP_MSB:0] = low_cmp_reg;
        end else if (hit(avs_address_i, `IRC_OFS_HIGH_CMP)) begin
            rdata_next[`IRC_CMP_MSB:0] = high_latch_reg;
        end else if (hit(avs_address_i, `IRC_OFS_CARRIER_CTL)) begin
            rdata_next[`IRC_BIT_NEXT_ENV]   = next_env_reg;
            rdata_next[`IRC_BIT_ACTIVE_ENV] = active_env_reg;
            rdata_next[`IRC_BIT_REMOTE_EN]  = remote_en_reg;
        end else if (hit(avs_address_i, `IRC_OFS_STATUS)) begin
            rdata_next[`IRC_CMP_MSB:0]    = cnt_reg;
            rdata_next[`IRC_BIT_CARRIER] = carrier_reg;
            rdata_next[`IRC_BIT_PHASE]   = phase_reg;
            rdata_next[`IRC_BIT_PENDING] = high_pend_reg;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    // low compare is taken as written; rewriting it while running is
    // left to software discipline, as is keeping both above zero
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            run_reg       <= 1'b0;
            env_run_reg   <= 1'b0;
            remote_en_reg <= 1'b0;
            next_env_reg  <= 1'b0;
            low_cmp_reg   <= `IRC_CMP_RST;
        end else if (wr_acc) begin
            if (hit(avs_address_i, `IRC_OFS_RUN_CTRL)) begin
                run_reg     <= avs_writedata_i[`IRC_BIT_RUN];
                env_run_reg <= avs_writedata_i[`IRC_BIT_ENV_RUN];
            end
            if (hit(avs_address_i, `IRC_OFS_LOW_CMP)) begin
                low_cmp_reg <= avs_writedata_i[`IRC_CMP_MSB:0];
            end
            if (hit(avs_address_i, `IRC_OFS_CARRIER_CTL)) begin
                next_env_reg  <= avs_writedata_i[`IRC_BIT_NEXT_ENV];
                remote_en_reg <= avs_writedata_i[`IRC_BIT_REMOTE_EN];
            end
        end
    end

    // ------------------------------------------------------------------
    // high-width compare with latched update
    // ------------------------------------------------------------------
    assign cmp_sel  = phase_reg ? high_cmp_reg : low_cmp_reg;
    assign counting = run_reg & count_tick_i & ~mask_reg;
    assign match    = counting & (cnt_reg == cmp_sel);

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            high_cmp_reg   <= `IRC_CMP_RST;
            high_latch_reg <= `IRC_CMP_RST;
            high_pend_reg  <= 1'b0;
            high_age_reg   <= `IRC_AGE_ZERO;
        end else if (wr_acc & hit(avs_address_i, `IRC_OFS_HIGH_CMP)) begin
            high_latch_reg <= avs_writedata_i[`IRC_CMP_MSB:0];
            if (run_reg) begin
                high_pend_reg <= 1'b1;
                high_age_reg  <= `IRC_AGE_ZERO;
            end else begin
                high_cmp_reg  <= avs_writedata_i[`IRC_CMP_MSB:0];
                high_pend_reg <= 1'b0;
            end
        end else begin
            if (match & phase_reg & high_pend_reg &
                (high_age_reg == `IRC_AGE_XFER)) begin
                high_cmp_reg  <= high_latch_reg;
                high_pend_reg <= 1'b0;
            end else if (high_pend_reg & count_tick_i &
                         (high_age_reg != `IRC_AGE_XFER)) begin
                high_age_reg <= high_age_reg + `IRC_AGE_ONE;
            end
        end
    end

    // ------------------------------------------------------------------
    // carrier counter
    // ------------------------------------------------------------------
    // each phase lasts compare+1 count clocks, so the period is N+M+2
    always @* begin
        carrier_next = carrier_reg;
        if (~run_reg) begin
            carrier_next = 1'b0;
        end else if (match) begin
            carrier_next = ~carrier_reg;
        end
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            cnt_reg     <= `IRC_CNT_ZERO;
            phase_reg   <= 1'b0;
            carrier_reg <= 1'b0;
            mask_reg    <= 1'b1;
            cmi_reg     <= 1'b0;
        end else begin
            carrier_reg <= carrier_next;
            cmi_reg     <= match;
            if (~run_reg) begin
                cnt_reg   <= `IRC_CNT_ZERO;
                phase_reg <= 1'b0;
                mask_reg  <= 1'b1;
            end else if (count_tick_i & mask_reg) begin
                mask_reg <= 1'b0;
            end else if (match) begin
                cnt_reg   <= `IRC_CNT_ZERO;
                phase_reg <= ~phase_reg;
            end else if (counting) begin
                cnt_reg <= cnt_reg + `IRC_CNT_ONE;
            end
        end
    end

    // ------------------------------------------------------------------
    // envelope transfer
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            env_sync_d_reg <= 1'b0;
            env_seen_reg   <= 1'b0;
            xfer_sr_reg    <= `IRC_SR_ZERO;
            active_env_reg <= 1'b0;
            sev_reg        <= 1'b0;
        end else begin
            env_sync_d_reg <= env_sync;
            sev_reg        <= env_event;
            if (count_tick_i) begin
                env_seen_reg <= 1'b0;
                xfer_sr_reg  <= {xfer_sr_reg[0], env_event};
                if (xfer_sr_reg[1]) begin
                    active_env_reg <= next_env_reg;
                end
            end else if (env_rise) begin
                env_seen_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // output gating
    // ------------------------------------------------------------------
    // gate opens only on a carrier rise and closes only while the
    // carrier is low, so no high pulse is ever cut short
    always @* begin
        if (active_env_reg) begin
            gate_next = gate_reg | (carrier_next & ~carrier_reg);
        end else begin
            gate_next = gate_reg & carrier_next;
        end
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            gate_reg <= 1'b0;
            out_reg  <= 1'b0;
        end else begin
            gate_reg <= gate_next;
            if (remote_en_reg) begin
                out_reg <= gate_next & carrier_next;
            end else begin
                out_reg <= next_env_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign avs_readdata_o          = rdata_reg;
    assign avs_waitrequest_o       = wait_reg;
    assign carrier_output_pin_o    = out_reg;
    assign compare_match_irq_o     = cmi_reg;
    assign synced_envelope_event_o = sev_reg;
    assign envelope_timer_run_o    = env_run_reg;

endmodule

// ==== hw/irc_defs.vh ====
// Purpose: shared constants of the infrared carrier generator
// Assumes: included by its bare name from the design files
// Notes:   register offsets are byte addresses on a 32-bit Avalon-MM slave
`ifndef IRC_DEFS_VH
`define IRC_DEFS_VH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define IRC_ADDR_W          5
`define IRC_OFS_RUN_CTRL    5'h00
`define IRC_OFS_LOW_CMP     5'h04
`define IRC_OFS_HIGH_CMP    5'h08
`define IRC_OFS_CARRIER_CTL 5'h0C
`define IRC_OFS_STATUS      5'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IRC_BIT_RUN         0
`define IRC_BIT_ENV_RUN     1
`define IRC_BIT_NEXT_ENV    0
`define IRC_BIT_ACTIVE_ENV  1
`define IRC_BIT_REMOTE_EN   2
`define IRC_BIT_CARRIER     8
`define IRC_BIT_PHASE       9
`define IRC_BIT_PENDING     10
`define IRC_CMP_MSB         7

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define IRC_CMP_RST         8'hFF
`define IRC_CNT_ZERO        8'h00
`define IRC_CNT_ONE         8'h01
`define IRC_AGE_ZERO        2'h0
`define IRC_AGE_ONE         2'h1
`define IRC_AGE_XFER        2'h3
`define IRC_SR_ZERO         2'h0
`define IRC_DATA_ZERO       32'h00000000

`endif

// ==== hw/irc_sync.v ====
// Purpose: two-stage synchroniser for the envelope event level
// Assumes: async_i may come from another clock domain
// Notes:   stage one feeds stage two only
`timescale 1ns/1ps

module irc_sync (
    input  wire clk_sys_i,   // system clock
    input  wire srst_i,      // synchronous reset, active high
    input  wire async_i,     // level from outside the domain
    output wire sync_o       // synchronised level
);

    reg meta_reg;
    reg sync_reg;

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

// ==== verification/irc_carrier_gen_tb.sv ====
// Purpose: self-checking bench for the carrier generator
// Assumes: one count tick every tdiv system cycles
// Notes:   pin high widths are checked whenever chk_w is set
`timescale 1ns/1ps
`include "irc_defs.vh"

module irc_carrier_gen_tb;
    logic        clk_sys_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        count_tick_i = 1'b0;
    logic [4:0]  avs_address_i = 5'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [3:0]  avs_byteenable_i = 4'hF;
    wire  [31:0] avs_readdata_o;
    wire         avs_waitrequest_o, carrier_output_pin_o, compare_match_irq_o;
    wire         synced_envelope_event_o, envelope_timer_run_o, envelope_timer_irq_i;
    int          miscompares = 0, comparisons = 0, tmo = 0, tcnt = 0, tdiv = 1;
    int          cyc = 0, hw = 0, npulse = 0, exp_w = 0, t0, np, k;
    bit          chk_w = 1'b0;
    int          mq[$];
    logic [31:0] q;

    irc_carrier_gen uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .count_tick_i(count_tick_i),
        .envelope_timer_irq_i(envelope_timer_irq_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .carrier_output_pin_o(carrier_output_pin_o),
        .compare_match_irq_o(compare_match_irq_o),
        .synced_envelope_event_o(synced_envelope_event_o),
        .envelope_timer_run_o(envelope_timer_run_o));
    irc_env_model env (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .run_i(envelope_timer_run_o),
        .irq_o(envelope_timer_irq_i));

    always #2 clk_sys_i = ~clk_sys_i;

    // ------------------------------------------------------------------
    // stimulus helpers and monitors
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        count_tick_i <= (tcnt == 0);
        tcnt <= (tcnt + 1 >= tdiv) ? 0 : tcnt + 1;
        tmo = tmo + 1;
        if (tmo == 20000) begin
            miscompares = miscompares + 1;
            end_sim();
        end
    end

    always @(negedge clk_sys_i) begin
        cyc = cyc + 1;
        if (compare_match_irq_o === 1'b1) mq.push_back(cyc);
        if (carrier_output_pin_o === 1'b1) hw = hw + 1;
        else if (hw != 0) begin
            if (chk_w) check(hw, exp_w);
            npulse = npulse + 1;
            hw = 0;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input bit rd, input [4:0] a, input [31:0] d, input [3:0] be,
                       output logic [31:0] r);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_read_i <= rd;
        avs_write_i <= !rd;
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        r = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input [4:0] a, input [31:0] d);
        logic [31:0] r;
        bus(1'b0, a, d, 4'hF, r);
    endtask

    task automatic rdc(input [4:0] a, input [31:0] e);
        logic [31:0] r;
        bus(1'b1, a, 32'h00000000, 4'hF, r);
        check(r, e);
    endtask

    task automatic wait_ev;
        int i;
        for (i = 0; i < 400 && synced_envelope_event_o !== 1'b1; i++) @(negedge clk_sys_i);
        check({31'h0, synced_envelope_event_o}, 32'h00000001);
    endtask

    task automatic end_sim;
        if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rdc(`IRC_OFS_RUN_CTRL, 32'h00000000);
        rdc(`IRC_OFS_LOW_CMP, 32'h000000FF);
        rdc(`IRC_OFS_HIGH_CMP, 32'h000000FF);
        rdc(`IRC_OFS_CARRIER_CTL, 32'h00000000);
        rdc(`IRC_OFS_STATUS, 32'h00000000);
        wr(5'h14, 32'hFFFFFFFF);
        rdc(5'h14, 32'h00000000);
        bus(1'b0, `IRC_OFS_LOW_CMP, 32'h00000005, 4'h0, q);
        rdc(`IRC_OFS_LOW_CMP, 32'h000000FF);
        // low width 3, high width 2; envelope still off
        wr(`IRC_OFS_LOW_CMP, 32'h00000002);
        wr(`IRC_OFS_HIGH_CMP, 32'h00000001);
        wr(`IRC_OFS_CARRIER_CTL, 32'h00000005);
        mq.delete();
        wr(`IRC_OFS_RUN_CTRL, 32'h00000001);
        t0 = cyc;
        repeat (30) @(posedge clk_sys_i);
        check(mq[0] - t0, 32'h00000005);
        check(mq[1] - mq[0], 32'h00000002);
        check(mq[2] - mq[1], 32'h00000003);
        check({31'h0, carrier_output_pin_o}, 32'h00000000);
        exp_w = 2;
        chk_w = 1'b1;
        wr(`IRC_OFS_RUN_CTRL, 32'h00000003);
        wait_ev();
        check({31'h0, envelope_timer_run_o}, 32'h00000001);
        repeat (4) @(posedge clk_sys_i);
        rdc(`IRC_OFS_CARRIER_CTL, 32'h00000007);
        repeat (40) @(posedge clk_sys_i);
        check(npulse > 5, 32'h00000001);
        wr(`IRC_OFS_CARRIER_CTL, 32'h00000004);
        wait_ev();
        repeat (20) @(posedge clk_sys_i);
        check({31'h0, carrier_output_pin_o}, 32'h00000000);
        // high width rewritten while counting, low width left alone, slower ticks
        chk_w = 1'b0;
        tdiv = 2;
        wr(`IRC_OFS_HIGH_CMP, 32'h00000003);
        bus(1'b1, `IRC_OFS_STATUS, 32'h00000000, 4'hF, q);
        check(q & 32'h00000400, 32'h00000400);
        wr(`IRC_OFS_CARRIER_CTL, 32'h00000005);
        repeat (40) @(posedge clk_sys_i);
        bus(1'b1, `IRC_OFS_STATUS, 32'h00000000, 4'hF, q);
        check(q & 32'h00000400, 32'h00000000);
        exp_w = 8;
        chk_w = 1'b1;
        np = npulse;
        wait_ev();
        repeat (60) @(posedge clk_sys_i);
        check(npulse > np, 32'h00000001);
        chk_w = 1'b0;
        wr(`IRC_OFS_RUN_CTRL, 32'h00000000);
        repeat (4) @(posedge clk_sys_i);
        mq.delete();
        bus(1'b1, `IRC_OFS_STATUS, 32'h00000000, 4'hF, q);
        check(q & 32'h000001FF, 32'h00000000);
        repeat (20) @(posedge clk_sys_i);
        check(mq.size(), 32'h00000000);
        check({31'h0, envelope_timer_run_o}, 32'h00000000);
        for (k = 0; k < 4; k++) begin
            wr(`IRC_OFS_CARRIER_CTL, {29'h0, k[1], 1'b0, k[0]});
            repeat (3) @(posedge clk_sys_i);
            check({31'h0, carrier_output_pin_o}, (k == 1) ? 32'h1 : 32'h0);
        end
        end_sim();
    end
endmodule

bind irc_carrier_gen irc_checker chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .count_tick_i(count_tick_i), .envelope_timer_irq_i(envelope_timer_irq_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .carrier_output_pin_o(carrier_output_pin_o), .compare_match_irq_o(compare_match_irq_o),
    .synced_envelope_event_o(synced_envelope_event_o),
    .envelope_timer_run_o(envelope_timer_run_o));

// ==== verification/irc_checker.sv ====
// Purpose: port-level assertions for the carrier generator
// Assumes: one clock, synchronous active-high reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ps

module irc_checker (
    input wire        clk_sys_i,               // clock
    input wire        srst_i,                  // reset
    input wire        count_tick_i,            // count pulse
    input wire        envelope_timer_irq_i,    // envelope event in
    input wire [4:0]  avs_address_i,           // address
    input wire        avs_read_i,              // read
    input wire        avs_write_i,             // write
    input wire [31:0] avs_writedata_i,         // write data
    input wire [3:0]  avs_byteenable_i,        // byte enables
    input wire [31:0] avs_readdata_o,          // read data
    input wire        avs_waitrequest_o,       // stall
    input wire        carrier_output_pin_o,    // pin
    input wire        compare_match_irq_o,     // match pulse
    input wire        synced_envelope_event_o, // synced event
    input wire        envelope_timer_run_o     // companion run
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    wire req = avs_read_i | avs_write_i;

    wait_answer_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered after one wait cycle");
    wait_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    wait_idle_a: assert property (!req && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest dropped without a request");
    match_pulse_a: assert property (compare_match_irq_o |=> !compare_match_irq_o)
        else $error("match pulse longer than one cycle");
    match_tick_a: assert property (compare_match_irq_o |-> $past(count_tick_i))
        else $error("match pulse without a count tick");
    env_tick_a: assert property (synced_envelope_event_o |-> $past(count_tick_i))
        else $error("envelope event not aligned to a count tick");
    env_pulse_a: assert property (synced_envelope_event_o |=> !synced_envelope_event_o)
        else $error("envelope event longer than one cycle");
    pin_rise_a: assert property ($rose(carrier_output_pin_o) |->
        compare_match_irq_o || $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("pin rose away from a carrier rising edge");
    pin_fall_a: assert property ($fell(carrier_output_pin_o) |->
        compare_match_irq_o || $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("pin fell inside a carrier high phase");
    env_run_a: assert property (!$stable(envelope_timer_run_o) |->
        $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("companion run level changed without a write");

    cover property (compare_match_irq_o);
    cover property ($rose(carrier_output_pin_o));
    cover property (synced_envelope_event_o);
endmodule

// ==== verification/irc_env_model.sv ====
// Purpose: companion interval timer model raising envelope events
// Assumes: same clock as the carrier generator
// Notes:   own count clock is the system clock divided by PRESCALE
`timescale 1ns/1ps

module irc_env_model #(
    parameter PRESCALE = 16, // slow enough to stay below the carrier rate
    parameter INTERVAL = 6   // own count clocks between events
) (
    input  wire clk_sys_i, // system clock
    input  wire srst_i,    // synchronous reset
    input  wire run_i,     // run level from the generator
    output reg  irq_o      // one-cycle envelope event
);
    reg [7:0] pre_reg;
    reg [7:0] cnt_reg;

    always @(posedge clk_sys_i) begin
        irq_o <= 1'b0;
        if (srst_i || !run_i) begin
            pre_reg <= 8'h00;
            cnt_reg <= 8'h00;
        end else if (pre_reg == PRESCALE - 1) begin
            pre_reg <= 8'h00;
            cnt_reg <= (cnt_reg == INTERVAL - 1) ? 8'h00 : cnt_reg + 8'h01;
            irq_o   <= (cnt_reg == INTERVAL - 1);
        end else begin
            pre_reg <= pre_reg + 8'h01;
        end
    end
endmodule
